// ==== hw/clk_cfg_pkg.sv ====
package clk_cfg_pkg;

   // Register byte offsets on the APB window
   localparam logic [11:0] OFF_BUS_PERIPHERAL_RESET = 12'h028;
   localparam logic [11:0] OFF_CLOCK_CONFIG_SECOND = 12'h02C;

   // Reset values of both registers
   localparam logic [31:0] RST_BUS_PERIPHERAL_RESET = 32'h0000_0000;
   localparam logic [31:0] RST_CLOCK_CONFIG_SECOND = 32'h0000_0000;

   // Bus reset register layout
   localparam int USB_RESET_BIT = 12;

   // Second configuration register layout
   localparam int PLL2_MSB_BIT = 31;
   localparam int PRESEL_BIT = 30;
   localparam int ADC_MSB_BIT = 29;
   localparam int AUDIO2_SEL_BIT = 18;
   localparam int AUDIO1_SEL_BIT = 17;
   localparam int PREDIV0_SEL_BIT = 16;
   localparam int PLL2_LO_HI = 15;
   localparam int PLL2_LO_LO = 12;
   localparam int PLL1_HI = 11;
   localparam int PLL1_LO = 8;
   localparam int PREDIV1_HI = 7;
   localparam int PREDIV1_LO = 4;
   localparam int PREDIV0_HI = 3;
   localparam int PREDIV0_LO = 0;

   // Bits that software can store; all others read as zero
   localparam logic [31:0] CFG1_RW_MASK = 32'hE007_FFFF;
   localparam logic [31:0] PREDIV1_MASK = 32'h0000_00F0;

   // Multiplier encodings: most codes are code plus an offset
   localparam logic [5:0] MUL_OFFSET = 6'h02;
   localparam logic [4:0] PLL2_FIRST_CODE = 5'h06;
   localparam logic [4:0] PLL2_CODE_X20 = 5'h0F;
   localparam logic [4:0] PLL2_CODE_X40 = 5'h1F;
   localparam logic [3:0] PLL1_FIRST_CODE = 4'h6;
   localparam logic [3:0] PLL1_CODE_X16 = 4'hE;
   localparam logic [3:0] PLL1_CODE_X20 = 4'hF;
   localparam logic [5:0] MUL_X16 = 6'h10;
   localparam logic [5:0] MUL_X20 = 6'h14;
   localparam logic [5:0] MUL_X40 = 6'h28;

   // Configuration fields as driven to the clock tree
   typedef struct packed {
      logic usb_fullspeed_reset_ctl;
      logic pll_source_preselect;
      logic adc_clock_prescale_msb;
      logic audio_port2_clock_select;
      logic audio_port1_clock_select;
      logic prediv0_input_select;
      logic [4:0] pll2_multiplier;
      logic [3:0] pll1_multiplier;
      logic [3:0] prediv1_factor;
      logic [3:0] prediv0_factor;
   } cfg_fields_t;

   // Decoded multiply and divide ratios
   typedef struct packed {
      logic [5:0] pll2_mult_value;
      logic pll2_mult_reserved;
      logic [5:0] pll1_mult_value;
      logic pll1_mult_reserved;
      logic [4:0] prediv1_ratio;
      logic [4:0] prediv0_ratio;
   } ratio_info_t;

endpackage

// ==== hw/pll_mult_decode.sv ====
// Turns the PLL multiplier codes into multiply factors; reserved codes give zero
module pll_mult_decode (
   input wire logic [4:0] pll2_code,
   input wire logic [3:0] pll1_code,
   output logic [5:0] pll2_value,
   output logic pll2_reserved,
   output logic [5:0] pll1_value,
   output logic pll1_reserved
);

   // Five-bit code: two irregular steps at 0x0F and 0x1F
   function automatic logic [5:0] pll2_factor(input logic [4:0] c);
      if (c < clk_cfg_pkg::PLL2_FIRST_CODE) begin
         pll2_factor = 6'h00;
      end else if (c == clk_cfg_pkg::PLL2_CODE_X20) begin
         pll2_factor = clk_cfg_pkg::MUL_X20;
      end else if (c == clk_cfg_pkg::PLL2_CODE_X40) begin
         pll2_factor = clk_cfg_pkg::MUL_X40;
      end else begin
         pll2_factor = {1'b0, c} + clk_cfg_pkg::MUL_OFFSET;
      end
   endfunction

   // Four-bit code: linear up to 0x0D, then x16 and x20
   function automatic logic [5:0] pll1_factor(input logic [3:0] c);
      if (c < clk_cfg_pkg::PLL1_FIRST_CODE) begin
         pll1_factor = 6'h00;
      end else if (c == clk_cfg_pkg::PLL1_CODE_X16) begin
         pll1_factor = clk_cfg_pkg::MUL_X16;
      end else if (c == clk_cfg_pkg::PLL1_CODE_X20) begin
         pll1_factor = clk_cfg_pkg::MUL_X20;
      end else begin
         pll1_factor = {2'b00, c} + clk_cfg_pkg::MUL_OFFSET;
      end
   endfunction

   assign pll2_value = pll2_factor(pll2_code);
   assign pll2_reserved = (pll2_code < clk_cfg_pkg::PLL2_FIRST_CODE);
   assign pll1_value = pll1_factor(pll1_code);
   assign pll1_reserved = (pll1_code < clk_cfg_pkg::PLL1_FIRST_CODE);

endmodule

// ==== hw/prediv_ratio.sv ====
// Divide ratio of a pre-divider: the code plus one
module prediv_ratio #(
   parameter int W = 4
) (
   input wire logic [W-1:0] code,
   output logic [W:0] ratio
);

   assign ratio = {1'b0, code} + {{W{1'b0}}, 1'b1};

endmodule

// ==== hw/pll_and_peripheral_clock_config.sv ====
// Chosen here: register access over APB.
module pll_and_peripheral_clock_config #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cfg0_prediv0_lsb_we,
   input wire logic cfg0_prediv0_lsb_wdata,
   input wire logic pll1_enabled,
   input wire logic pll2_enabled,
   output clk_cfg_pkg::cfg_fields_t cfg_fields,
   output clk_cfg_pkg::ratio_info_t ratio_info
);

   // Whole state of the block in one word
   typedef struct packed {
      logic usb_rst;
      logic [31:0] cfg1;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      clk_cfg_pkg::ratio_info_t ratio;
   } state_t;

   state_t s_q; // Registered state
   state_t s_d; // Next state

   // Decoder results, taken from the stored register
   logic [5:0] pll2_val;
   logic pll2_rsv;
   logic [5:0] pll1_val;
   logic pll1_rsv;
   logic [4:0] pdiv1_val;
   logic [4:0] pdiv0_val;

   // Bus phase terms
   logic access;     // Access phase of any transfer
   logic done;       // Edge where the master samples pready
   logic hit_rst;    // Address selects the bus reset register
   logic hit_cfg;    // Address selects the second config register
   logic [31:0] bmask; // Byte lanes enabled by pstrb

   // Expand byte strobes to a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // Place the reset bit into a read word; the rest reads zero
   function automatic logic [31:0] rst_word(input logic b);
      rst_word = 32'h0000_0000;
      rst_word[clk_cfg_pkg::USB_RESET_BIT] = b;
   endfunction

   // Multiplier codes come straight from the stored fields
   pll_mult_decode u_mult (
      .pll2_code({s_q.cfg1[clk_cfg_pkg::PLL2_MSB_BIT],
                  s_q.cfg1[clk_cfg_pkg::PLL2_LO_HI:clk_cfg_pkg::PLL2_LO_LO]}),
      .pll1_code(s_q.cfg1[clk_cfg_pkg::PLL1_HI:clk_cfg_pkg::PLL1_LO]),
      .pll2_value(pll2_val),
      .pll2_reserved(pll2_rsv),
      .pll1_value(pll1_val),
      .pll1_reserved(pll1_rsv)
   );

   // Pre-divider 1 ratio
   prediv_ratio #(
      .W(4)
   ) u_pdiv1 (
      .code(s_q.cfg1[clk_cfg_pkg::PREDIV1_HI:clk_cfg_pkg::PREDIV1_LO]),
      .ratio(pdiv1_val)
   );

   // Pre-divider 0 ratio
   prediv_ratio #(
      .W(4)
   ) u_pdiv0 (
      .code(s_q.cfg1[clk_cfg_pkg::PREDIV0_HI:clk_cfg_pkg::PREDIV0_LO]),
      .ratio(pdiv0_val)
   );

   // Address decode; misaligned addresses match nothing
   assign hit_rst = (paddr == ADDR_W'(clk_cfg_pkg::OFF_BUS_PERIPHERAL_RESET));
   assign hit_cfg = (paddr == ADDR_W'(clk_cfg_pkg::OFF_CLOCK_CONFIG_SECOND));
   assign access = psel && penable;
   assign done = access && s_q.pready;
   assign bmask = lane_mask(pstrb);

   // Next-state logic: one wait state per transfer, writes at completion
   always_comb begin
      s_d = s_q;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
      // Answer in the second access cycle; the wait keeps prdata a flop output
      if (access && !s_q.pready) begin
         s_d.pready = 1'b1;
         s_d.pslverr = !(hit_rst || hit_cfg);
         if (!pwrite && hit_rst) begin
            s_d.prdata = rst_word(s_q.usb_rst);
         end else if (!pwrite && hit_cfg) begin
            s_d.prdata = s_q.cfg1 & clk_cfg_pkg::CFG1_RW_MASK;
         end
      end
      // Writes take effect on the edge the master sees pready
      if (done && pwrite && hit_rst && bmask[clk_cfg_pkg::USB_RESET_BIT]) begin
         // Other bits are not stored, so a stray write there is harmless
         s_d.usb_rst = pwdata[clk_cfg_pkg::USB_RESET_BIT];
      end
      if (done && pwrite && hit_cfg) begin
         // Merge only enabled lanes of defined fields
         s_d.cfg1 = (s_q.cfg1 & ~(bmask & clk_cfg_pkg::CFG1_RW_MASK))
                  | (pwdata & bmask & clk_cfg_pkg::CFG1_RW_MASK);
         // Pre-divider 1 is frozen while either PLL runs, to avoid a glitch
         if (pll1_enabled || pll2_enabled) begin
            s_d.cfg1 = (s_d.cfg1 & ~clk_cfg_pkg::PREDIV1_MASK)
                     | (s_q.cfg1 & clk_cfg_pkg::PREDIV1_MASK);
         end
      end
      // Shared storage: a config0 write lands last, so it wins a tie
      if (cfg0_prediv0_lsb_we) begin
         s_d.cfg1[clk_cfg_pkg::PREDIV0_LO] = cfg0_prediv0_lsb_wdata;
      end
      // Decoded ratios follow the fields by one cycle
      s_d.ratio.pll2_mult_value = pll2_val;
      s_d.ratio.pll2_mult_reserved = pll2_rsv;
      s_d.ratio.pll1_mult_value = pll1_val;
      s_d.ratio.pll1_mult_reserved = pll1_rsv;
      s_d.ratio.prediv1_ratio = pdiv1_val;
      s_d.ratio.prediv0_ratio = pdiv0_val;
   end

   // State register; both registers clear to zero so USB runs after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.usb_rst <= clk_cfg_pkg::RST_BUS_PERIPHERAL_RESET[clk_cfg_pkg::USB_RESET_BIT];
         s_q.cfg1 <= clk_cfg_pkg::RST_CLOCK_CONFIG_SECOND;
         s_q.pready <= 1'b0;
         s_q.pslverr <= 1'b0;
         s_q.prdata <= 32'h0000_0000;
         s_q.ratio <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Bus outputs
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;

   // Field outputs, each taken from bits of the stored registers
   assign cfg_fields.usb_fullspeed_reset_ctl = s_q.usb_rst;
   assign cfg_fields.pll_source_preselect = s_q.cfg1[clk_cfg_pkg::PRESEL_BIT];
   assign cfg_fields.adc_clock_prescale_msb = s_q.cfg1[clk_cfg_pkg::ADC_MSB_BIT];
   assign cfg_fields.audio_port2_clock_select = s_q.cfg1[clk_cfg_pkg::AUDIO2_SEL_BIT];
   assign cfg_fields.audio_port1_clock_select = s_q.cfg1[clk_cfg_pkg::AUDIO1_SEL_BIT];
   assign cfg_fields.prediv0_input_select = s_q.cfg1[clk_cfg_pkg::PREDIV0_SEL_BIT];
   assign cfg_fields.pll2_multiplier = {s_q.cfg1[clk_cfg_pkg::PLL2_MSB_BIT],
      s_q.cfg1[clk_cfg_pkg::PLL2_LO_HI:clk_cfg_pkg::PLL2_LO_LO]};
   assign cfg_fields.pll1_multiplier =
      s_q.cfg1[clk_cfg_pkg::PLL1_HI:clk_cfg_pkg::PLL1_LO];
   assign cfg_fields.prediv1_factor = s_q.cfg1[clk_cfg_pkg::PREDIV1_HI:clk_cfg_pkg::PREDIV1_LO];
   assign cfg_fields.prediv0_factor = s_q.cfg1[clk_cfg_pkg::PREDIV0_HI:clk_cfg_pkg::PREDIV0_LO];
   assign ratio_info = s_q.ratio;

   // Reset bit follows a completed write with byte lane 1 enabled one edge later
   a_usb_rst_write: assert property (@(posedge pclk) disable iff (!presetn)
      (done && pwrite && hit_rst && pstrb[1]) |=> (cfg_fields.usb_fullspeed_reset_ctl
         == $past(pwdata[clk_cfg_pkg::USB_RESET_BIT])))
      else $error("usb reset bit did not follow write");

   // Reserved bus-reset bits read as zero
   a_rst_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pready && !pwrite && hit_rst) |=>
         (pready && (prdata == rst_word(cfg_fields.usb_fullspeed_reset_ctl))))
      else $error("bus reset readback wrong");

   // Every transfer answers after exactly one wait cycle
   a_access_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) ##1 (psel && penable) |=> pready)
      else $error("no answer one cycle into access");

   // Config readback matches the fields it drives
   a_cfg_readback: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pready && !pwrite && hit_cfg) |=>
         (prdata[clk_cfg_pkg::PRESEL_BIT] == cfg_fields.pll_source_preselect
          && prdata[clk_cfg_pkg::PLL2_MSB_BIT] == cfg_fields.pll2_multiplier[4]
          && prdata[28:19] == 10'h000 && !pslverr))
      else $error("second config readback wrong");

   // Unmapped addresses answer with an error
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pready && !hit_rst && !hit_cfg) |=> (pready && pslverr))
      else $error("unmapped access not flagged");

   // Source selects take the written value
   a_select_write: assert property (@(posedge pclk) disable iff (!presetn)
      (done && pwrite && hit_cfg && pstrb[2] && pstrb[3] && !cfg0_prediv0_lsb_we) |=>
         ({cfg_fields.pll_source_preselect, cfg_fields.audio_port2_clock_select,
           cfg_fields.audio_port1_clock_select, cfg_fields.prediv0_input_select,
           cfg_fields.adc_clock_prescale_msb} ==
          {$past(pwdata[30]), $past(pwdata[18]), $past(pwdata[17]), $past(pwdata[16]),
           $past(pwdata[29])}))
      else $error("select bits did not follow write");

   // PLL2 code 0x1F decoded as x40 two cycles after the write
   a_pll2_decode: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg_fields.pll2_multiplier == clk_cfg_pkg::PLL2_CODE_X40) ##1
      (cfg_fields.pll2_multiplier == clk_cfg_pkg::PLL2_CODE_X40) |->
         (ratio_info.pll2_mult_value == clk_cfg_pkg::MUL_X40 && !ratio_info.pll2_mult_reserved))
      else $error("pll2 x40 decode wrong");

   // PLL1 reserved codes flagged, code 0x0E decoded as x16; the release edge is skipped,
   // because the ratios are still held at zero by reset there
   a_pll1_decode: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && $stable(cfg_fields.pll1_multiplier)) |=>
         (ratio_info.pll1_mult_reserved
          == ($past(cfg_fields.pll1_multiplier) < clk_cfg_pkg::PLL1_FIRST_CODE))
         && (($past(cfg_fields.pll1_multiplier) != clk_cfg_pkg::PLL1_CODE_X16)
             || ratio_info.pll1_mult_value == clk_cfg_pkg::MUL_X16))
      else $error("pll1 decode wrong");

   // Pre-divider 1 holds while a PLL runs
   a_prediv1_locked: assert property (@(posedge pclk) disable iff (!presetn)
      (done && pwrite && (pll1_enabled || pll2_enabled)) |=> $stable(cfg_fields.prediv1_factor))
      else $error("pre-divider 1 changed with PLL on");

   // Shared bit follows the config0 strobe
   a_prediv0_shared: assert property (@(posedge pclk) disable iff (!presetn)
      cfg0_prediv0_lsb_we |=> (cfg_fields.prediv0_factor[0] == $past(cfg0_prediv0_lsb_wdata)))
      else $error("shared pre-divider bit lost");

   // PLL2 field is split across bit 31 and 15:12
   a_pll2_split: assert property (@(posedge pclk) disable iff (!presetn)
      (done && pwrite && hit_cfg && (&pstrb)) |=>
         (cfg_fields.pll2_multiplier == {$past(pwdata[31]), $past(pwdata[15:12])}))
      else $error("pll2 field split wrong");

endmodule

// ==== dv/test_pll_and_peripheral_clock_config.sv ====
module test_pll_and_peripheral_clock_config;
   timeunit 1ns;
   timeprecision 100ps;

   // Bus and side-band stimulus
   logic pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic pready, pslverr;
   logic lsb_we, lsb_wdata, pll1_en, pll2_en;
   // Observed configuration outputs
   clk_cfg_pkg::cfg_fields_t cfg_fields;
   clk_cfg_pkg::ratio_info_t ratio_info;
   // Bench copy of both registers, updated only from what software wrote
   logic [31:0] m_rst, m_cfg;
   int n_errors, n_checks;

   pll_and_peripheral_clock_config #(.ADDR_W(12)) uut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .cfg0_prediv0_lsb_we(lsb_we),
      .cfg0_prediv0_lsb_wdata(lsb_wdata),
      .pll1_enabled(pll1_en),
      .pll2_enabled(pll2_en),
      .cfg_fields(cfg_fields),
      .ratio_info(ratio_info)
   );

   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Prints the verdict and stops; shared by the main sequence and the watchdog
   task automatic wrap_up();
      if (n_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Four-state compare so an unknown never counts as a match
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Field layout worked out bit by bit from the register map
   function automatic clk_cfg_pkg::cfg_fields_t exp_fields(input logic [31:0] r,
                                                          input logic [31:0] c);
      return {r[12], c[30], c[29], c[18], c[17], c[16], c[31], c[15:12], c[11:8],
              c[7:4], c[3:0]};
   endfunction

   // Multiplier and divider decode; reserved codes give a zero factor
   function automatic clk_cfg_pkg::ratio_info_t exp_ratio(input logic [31:0] c);
      logic [4:0] p2;
      logic [3:0] p1;
      clk_cfg_pkg::ratio_info_t r;
      p2 = {c[31], c[15:12]};
      p1 = c[11:8];
      r.pll2_mult_reserved = (p2 < 5'h06);
      r.pll2_mult_value = r.pll2_mult_reserved ? 6'h00 : (p2 == 5'h0F) ? 6'h14 :
                          (p2 == 5'h1F) ? 6'h28 : {1'b0, p2} + 6'h02;
      r.pll1_mult_reserved = (p1 < 4'h6);
      r.pll1_mult_value = r.pll1_mult_reserved ? 6'h00 : (p1 == 4'hE) ? 6'h10 :
                          (p1 == 4'hF) ? 6'h14 : {2'b00, p1} + 6'h02;
      r.prediv1_ratio = {1'b0, c[7:4]} + 5'h01;
      r.prediv0_ratio = {1'b0, c[3:0]} + 5'h01;
      return r;
   endfunction

   // One APB transfer; holds the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Compares both output structs with the bench copy
   task automatic see();
      chk({9'h000, cfg_fields}, {9'h000, exp_fields(m_rst, m_cfg)},
          "fields");
      chk({8'h00, ratio_info}, {8'h00, exp_ratio(m_cfg)},
          "ratios");
   endtask

   // Write with byte strobes, then follow it in the bench copy
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] rd, m;
      logic er, bad;
      bad = !(a == clk_cfg_pkg::OFF_BUS_PERIPHERAL_RESET ||
              a == clk_cfg_pkg::OFF_CLOCK_CONFIG_SECOND);
      apb(1'b1, a, d, s, rd, er);
      chk({31'h0000_0000, er}, {31'h0000_0000, bad}, "write error flag");
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      if (a == clk_cfg_pkg::OFF_BUS_PERIPHERAL_RESET) begin
         m_rst = ((m_rst & ~m) | (d & m)) & (32'h0000_0001 << clk_cfg_pkg::USB_RESET_BIT);
      end
      if (a == clk_cfg_pkg::OFF_CLOCK_CONFIG_SECOND) begin
         // The pre-divider 1 field is frozen while either PLL runs
         if (pll1_en | pll2_en) begin
            m = m & ~clk_cfg_pkg::PREDIV1_MASK;
         end
         m_cfg = ((m_cfg & ~m) | (d & m)) & clk_cfg_pkg::CFG1_RW_MASK;
      end
      // Fields land one edge after the write, the decoded ratios one later
      repeat (2) @(posedge pclk);
      #1;
      see();
   endtask

   // Read back and compare; unmapped places answer zero with an error
   task automatic rdchk(input logic [11:0] a);
      logic [31:0] rd, e;
      logic er;
      e = (a == clk_cfg_pkg::OFF_BUS_PERIPHERAL_RESET) ? m_rst :
          (a == clk_cfg_pkg::OFF_CLOCK_CONFIG_SECOND) ? m_cfg : 32'h0000_0000;
      apb(1'b0, a, 32'h0000_0000, 4'h0, rd, er);
      chk(rd, e, "read data");
      chk({31'h0000_0000, er}, {31'h0000_0000, e === 32'h0000_0000 && !(
          a == clk_cfg_pkg::OFF_BUS_PERIPHERAL_RESET ||
          a == clk_cfg_pkg::OFF_CLOCK_CONFIG_SECOND) ? 1'b1 : 1'b0}, "read error flag");
   endtask

   // Pulse the shared pre-divider 0 bit from the first configuration register
   task automatic lsb(input logic v);
      @(posedge pclk);
      lsb_we <= 1'b1;
      lsb_wdata <= v;
      @(posedge pclk);
      lsb_we <= 1'b0;
      m_cfg[0] = v;
      @(posedge pclk);
      #1;
      see();
   endtask

   // Watchdog: the whole run needs under a thousand cycles
   initial begin
      #200_000;
      n_errors++;
      $display("mismatch at %0t: run timed out", $time);
      wrap_up();
   end

   // Main sequence
   initial begin
      logic [11:0] a;
      logic [31:0] d;
      logic [4:0] c;
      logic [3:0] s;
      {presetn, psel, penable, pwrite, lsb_we, lsb_wdata, pll1_en, pll2_en} = 8'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      m_rst = 32'h0000_0000;
      m_cfg = 32'h0000_0000;
      void'($urandom(32'h0000_533f));
      repeat (7) @(posedge pclk);
      #1;
      chk({8'h00, cfg_fields, 1'b0}, 32'h0000_0000, "fields in reset");
      // Release on a rising edge, like every other input
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      #1;
      see();
      rdchk(clk_cfg_pkg::OFF_BUS_PERIPHERAL_RESET);
      rdchk(clk_cfg_pkg::OFF_CLOCK_CONFIG_SECOND);
      // Every multiplier code and every divider code, with both PLLs off
      for (int i = 0; i < 32; i++) begin
         c = i[4:0];
         d = {c[4], 15'h0000, c[3:0], c[3:0], c[3:0], ~c[3:0]};
         wr(clk_cfg_pkg::OFF_CLOCK_CONFIG_SECOND, d, 4'hF);
      end
      // Pre-divider 1 ignores writes while either PLL runs
      @(posedge pclk);
      pll2_en <= 1'b1;
      wr(clk_cfg_pkg::OFF_CLOCK_CONFIG_SECOND, m_cfg ^ 32'h0000_00F1, 4'hF);
      @(posedge pclk);
      pll2_en <= 1'b0;
      pll1_en <= 1'b1;
      wr(clk_cfg_pkg::OFF_CLOCK_CONFIG_SECOND, m_cfg ^ 32'h0000_00F0, 4'hF);
      lsb(1'b1);
      lsb(1'b0);
      // Random traffic over both registers and unmapped or misaligned places
      for (int i = 0; i < 60; i++) begin
         case ($urandom_range(0, 5))
            0, 1: a = clk_cfg_pkg::OFF_BUS_PERIPHERAL_RESET;
            2, 3: a = clk_cfg_pkg::OFF_CLOCK_CONFIG_SECOND;
            4: a = 12'h030;
            default: a = 12'h029;
         endcase
         @(posedge pclk);
         pll1_en <= ($urandom_range(0, 3) == 0);
         pll2_en <= ($urandom_range(0, 3) == 0);
         d = $urandom;
         // Software keeps the reserved bus-reset bits at zero
         if (a == clk_cfg_pkg::OFF_BUS_PERIPHERAL_RESET) begin
            d = d & (32'h0000_0001 << clk_cfg_pkg::USB_RESET_BIT);
         end
         s = $urandom_range(0, 1) ? 4'hF : 4'($urandom_range(0, 15));
         wr(a, d, s);
         rdchk(a);
         if ($urandom_range(0, 3) == 0) begin
            lsb(1'($urandom_range(0, 1)));
         end
      end
      // A second reset in mid-run clears both registers again
      @(posedge pclk);
      presetn <= 1'b0;
      m_rst = 32'h0000_0000;
      m_cfg = 32'h0000_0000;
      @(posedge pclk);
      #1;
      chk({9'h000, cfg_fields}, 32'h0000_0000, "fields after reset");
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      #1;
      see();
      rdchk(clk_cfg_pkg::OFF_BUS_PERIPHERAL_RESET);
      rdchk(clk_cfg_pkg::OFF_CLOCK_CONFIG_SECOND);
      wrap_up();
   end

endmodule
